// file: dpa_map.vh
// timing constants and rule overview for the dual-port ram host controller
// Overview of operation
// - this host changes the address only while the write strobe and chip select are high.
// - this host holds one selection, array or flag, steady for the whole write window.
// - this host stretches a strobe-controlled write while output drive is on to cover turn-off and data setup.
// - in slave mode the conflict input must be asserted by the start of the write, which is then inhibited.
// - after the conflict flag releases, this host keeps the write asserted for the write-hold time.
`ifndef DPA_MAP_VH
`define DPA_MAP_VH
`define DPA_CLK_NS 40
`define DPA_WP_NS 20
`define DPA_WZ_DW_NS 30
`define DPA_WH_NS 25
`define DPA_P2P_NS 50
`define DPA_SPS_NS 5
`define DPA_SETUP_NS 0
`endif

// file: dpa_cnt.v
// down counter used to time one phase of a ram cycle
module dpa_cnt #(
	parameter W = 4
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_load,
	input wire [W-1:0] i_value,
	output wire o_done
);
	reg [W-1:0] cnt_q;
	always @(posedge i_clock) begin
		if (i_rst) begin
			cnt_q <= {W{1'b0}};
		end else if (i_load) begin
			cnt_q <= i_value;
		end else if (cnt_q != {W{1'b0}}) begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
		end
	end
	assign o_done = (cnt_q == {W{1'b0}}) && !i_load;
endmodule // dpa_cnt

// file: dpa_host.v
// host controller driving one port of the dual-port ram
`include "dpa_map.vh"
module dpa_host #(
	parameter AW = 12,
	parameter DW = 16
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_req,
	input wire i_write,
	input wire i_flag,
	input wire [1:0] i_bytes,
	input wire i_oe_low,
	input wire [AW-1:0] i_addr,
	input wire [DW-1:0] i_wdata,
	output reg o_busy,
	output reg o_done,
	output reg [DW-1:0] o_rdata,
	output reg o_chip_select_n,
	output reg o_write_not_read,
	output reg o_upper_byte_sel_n,
	output reg o_lower_byte_sel_n,
	output reg o_flag_select_n,
	output reg o_output_drive_n,
	output reg [AW-1:0] o_addr,
	output reg [DW-1:0] o_data_out,
	output reg o_data_oe,
	input wire [DW-1:0] i_data_in,
	input wire i_port_conflict_n
);
	function [3:0] ns2cyc;
		input integer ns;
		integer c;
		begin
			c = (ns + `DPA_CLK_NS - 1) / `DPA_CLK_NS;
			if (c < 1)
				c = 1;
			ns2cyc = c[3:0];
		end
	endfunction
	localparam [3:0] WP_CYC = ns2cyc(`DPA_WP_NS);
	localparam [3:0] WZDW_CYC = ns2cyc(`DPA_WZ_DW_NS);
	localparam [3:0] WH_CYC = ns2cyc(`DPA_WH_NS);
	localparam [3:0] RD_CYC = ns2cyc(`DPA_P2P_NS);
	localparam [3:0] WP_OE = (WZDW_CYC > WP_CYC) ? WZDW_CYC : WP_CYC;
	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_SETUP = 3'd1;
	localparam [2:0] S_STROBE = 3'd2;
	localparam [2:0] S_HOLD = 3'd3;
	localparam [2:0] S_END = 3'd4;
	reg [2:0] st_q;
	reg [DW-1:0] din_s1_q, din_s2_q;
	reg cf_s1_q, cf_s2_q, cf_seen_q;
	reg wr_q;
	reg flag_q;
	reg [1:0] bytes_q;
	reg [2:0] st_d;
	wire accept;
	reg ld;
	reg [3:0] ld_val;
	wire cnt_done;
	function state_is;
		input [2:0] cur;
		input [2:0] want;
		begin
			state_is = (cur == want);
		end
	endfunction
	assign accept = state_is(st_q, S_IDLE) && i_req;
	dpa_cnt #(.W(4)) u_cnt (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_load(ld),
		.i_value(ld_val),
		.o_done(cnt_done)
	);
	// pins from the ram pass two flops; conflict timing relies on the synchronised copy
	always @(posedge i_clock) begin
		din_s1_q <= i_data_in;
		din_s2_q <= din_s1_q;
		cf_s1_q <= i_port_conflict_n;
		cf_s2_q <= cf_s1_q;
	end
	always @* begin
		ld = 1'b0;
		ld_val = 4'h0;
		if (st_q == S_SETUP) begin
			ld = 1'b1;
			if (wr_q && !o_output_drive_n)
				ld_val = WP_OE;
			else if (wr_q)
				ld_val = WP_CYC;
			else
				ld_val = RD_CYC + 4'h2;
		end else if (st_q == S_STROBE && wr_q && cf_seen_q && cf_s2_q) begin
			ld = 1'b1;
			ld_val = WH_CYC;
		end
	end
	// next state; a blocked write stays open until the far side lets it go
	always @* begin
		st_d = st_q;
		case (st_q)
		S_IDLE: begin
			if (i_req) begin
				st_d = S_SETUP;
			end
		end
		S_SETUP: begin
			st_d = S_STROBE;
		end
		S_STROBE: begin
			if (ld) begin
				st_d = S_HOLD;
			end else if (cnt_done && !(wr_q && (cf_seen_q || !cf_s2_q))) begin
				st_d = S_END;
			end
		end
		S_HOLD: begin
			if (!cf_s2_q) begin
				// conflict is low again; wait for the next release
				st_d = S_STROBE;
			end else if (cnt_done) begin
				st_d = S_END;
			end
		end
		S_END: begin
			st_d = S_IDLE;
		end
		default: begin
			st_d = S_IDLE;
		end
		endcase
	end
	always @(posedge i_clock) begin
		if (i_rst) begin
			st_q <= S_IDLE;
		end else begin
			st_q <= st_d;
		end
	end
	// request fields are captured once, so the host bus may move during the cycle
	always @(posedge i_clock) begin
		if (i_rst) begin
			wr_q <= 1'b0;
			flag_q <= 1'b0;
			bytes_q <= 2'h0;
			o_addr <= {AW{1'b0}};
			o_data_out <= {DW{1'b0}};
		end else if (accept) begin
			// address moves only with all strobes high
			o_addr <= i_addr;
			wr_q <= i_write;
			flag_q <= i_flag;
			bytes_q <= i_bytes;
			o_data_out <= i_flag ? {DW{i_wdata[0]}} : i_wdata;
		end
	end
	always @(posedge i_clock) begin
		if (i_rst) begin
			cf_seen_q <= 1'b0;
		end else if (state_is(st_q, S_IDLE)) begin
			cf_seen_q <= 1'b0;
		end else if (state_is(st_q, S_STROBE) && wr_q && !cf_s2_q) begin
			cf_seen_q <= 1'b1; // write inhibited by conflict
		end
	end
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_chip_select_n <= 1'b1;
			o_write_not_read <= 1'b1;
			o_upper_byte_sel_n <= 1'b1;
			o_lower_byte_sel_n <= 1'b1;
			o_flag_select_n <= 1'b1;
			o_output_drive_n <= 1'b1;
			o_data_oe <= 1'b0;
		end else begin
			case (st_q)
			S_IDLE: begin
				// data stays driven one cycle past the strobe's rise, so no hold time is lost
				o_data_oe <= 1'b0;
				if (i_req) begin
					o_output_drive_n <= i_write ? !i_oe_low : 1'b0;
				end
			end
			S_SETUP: begin
				// one selection held through the window
				if (flag_q) begin
					o_flag_select_n <= 1'b0;
					o_upper_byte_sel_n <= 1'b1;
					o_lower_byte_sel_n <= 1'b1;
				end else begin
					o_chip_select_n <= 1'b0;
					o_upper_byte_sel_n <= !bytes_q[1];
					o_lower_byte_sel_n <= !bytes_q[0];
				end
				o_write_not_read <= !wr_q;
				o_data_oe <= wr_q;
			end
			S_END: begin
				o_write_not_read <= 1'b1;
				o_chip_select_n <= 1'b1;
				o_flag_select_n <= 1'b1;
				o_upper_byte_sel_n <= 1'b1;
				o_lower_byte_sel_n <= 1'b1;
				o_output_drive_n <= 1'b1;
			end
			default: begin
				// strobe and hold keep every pin as set up
			end
			endcase
		end
	end
	// status towards the host bus
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= {DW{1'b0}};
		end else begin
			o_done <= state_is(st_q, S_END);
			if (accept) begin
				o_busy <= 1'b1;
			end else if (state_is(st_q, S_END)) begin
				o_busy <= 1'b0;
			end
			// flag reads give the value on every line, all kept raw
			if (state_is(st_q, S_END) && !wr_q) begin
				o_rdata <= din_s2_q;
			end
		end
	end
endmodule // dpa_host

// file: dpa_host_chk_properties.sv
// pin sequencing checks for the ram host
module dpa_host_chk(
	input wire i_clock, i_rst, i_port_conflict_n, o_write_not_read, o_data_oe,
	input wire o_chip_select_n, o_upper_byte_sel_n, o_lower_byte_sel_n, o_flag_select_n,
	input wire o_output_drive_n,
	input wire [11:0] o_addr
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	wire w = o_write_not_read;
	wire c = i_port_conflict_n;
	wire [3:0] s = {o_chip_select_n, o_upper_byte_sel_n, o_lower_byte_sel_n, o_flag_select_n};
	property p_adr; !$stable(o_addr) |-> w || s[3] || s[2:1] == 2'h3; endproperty
	a_adr: assert property (p_adr) else $error("addr moved");
	property p_sel; !w && $past(!w) |-> $stable(s); endproperty
	a_sel: assert property (p_sel) else $error("select moved");
	property p_dat; !w |-> o_data_oe; endproperty
	a_dat: assert property (p_dat) else $error("data off");
	property p_wpw; $fell(w) && !o_output_drive_n |=> !w [*2]; endproperty
	a_wpw: assert property (p_wpw) else $error("pulse short");
	// the pin passes two sync flops, so only a conflict seen three cycles back must hold
	property p_inh; !w && !c && $past(!c, 3) |=> !w; endproperty
	a_inh: assert property (p_inh) else $error("write lost");
	property p_hld; $rose(c) && !w |=> !w [*2]; endproperty
	a_hld: assert property (p_hld) else $error("hold short");
	c_wr: cover property ($fell(w));
	c_fl: cover property (!w && !o_flag_select_n);
	c_cf: cover property (!w && !c);
endmodule // dpa_host_chk
bind dpa_host dpa_host_chk u_chk(.i_clock(i_clock), .i_rst(i_rst),
	.i_port_conflict_n(i_port_conflict_n), .o_write_not_read(o_write_not_read),
	.o_data_oe(o_data_oe), .o_chip_select_n(o_chip_select_n),
	.o_upper_byte_sel_n(o_upper_byte_sel_n), .o_lower_byte_sel_n(o_lower_byte_sel_n),
	.o_flag_select_n(o_flag_select_n), .o_output_drive_n(o_output_drive_n), .o_addr(o_addr));

// file: dpa_ram_mdl.sv
// behavioural ram port with one flag, far side of the host
module dpa_ram_mdl(
	input wire i_cs_n, i_we_n, i_ub_n, i_lb_n, i_fs_n, i_od_n, i_cn,
	input wire [11:0] i_a,
	input wire [15:0] i_d,
	output wire [15:0] o_q
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [15:0] mem [0:4095];
	reg [15:0] lst = 16'h0000;
	reg fl = 1'b1;
	wire rd = i_we_n && !i_od_n && !(i_cs_n && i_fs_n);
	wire [15:0] v = i_fs_n ? mem[i_a] : {16{fl}};
	// released pins show the inverse of the last value, never a kind default
	assign o_q = rd ? v : ~lst;
	always @* begin
		if (!i_we_n && i_cn && !i_cs_n && i_fs_n) begin
			if (!i_ub_n) mem[i_a][15:8] = i_d[15:8];
			if (!i_lb_n) mem[i_a][7:0] = i_d[7:0];
		end
		// one writer only, so no two strobes ever meet inside the contention window
		if (!i_we_n && i_cn && i_cs_n && !i_fs_n) fl = i_d[0];
		if (rd) lst = v;
	end
endmodule // dpa_ram_mdl

// file: tb.sv
// random and corner tests of the ram host
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 0, i_rst = 1, i_req = 0, i_write = 0, i_flag = 0, i_oe_low = 0;
	logic i_port_conflict_n = 1;
	logic [1:0] i_bytes = 0, b;
	logic [3:0] a;
	logic [11:0] i_addr = 0;
	logic [15:0] i_wdata = 0, r, sh [0:15];
	wire o_busy, o_done, o_chip_select_n, o_write_not_read, o_upper_byte_sel_n;
	wire o_lower_byte_sel_n, o_flag_select_n, o_output_drive_n, o_data_oe;
	wire [11:0] o_addr;
	wire [15:0] o_rdata, o_data_out, q, i_data_in = o_data_oe ? o_data_out : q;
	int miscompares = 0, cmp_count = 0, seed = 32'h9626, n;
	always #20 i_clock = ~i_clock;
	dpa_host u_dpa_host(.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .i_write(i_write),
		.i_flag(i_flag), .i_bytes(i_bytes), .i_oe_low(i_oe_low), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
		.o_chip_select_n(o_chip_select_n), .o_write_not_read(o_write_not_read),
		.o_upper_byte_sel_n(o_upper_byte_sel_n), .o_lower_byte_sel_n(o_lower_byte_sel_n),
		.o_flag_select_n(o_flag_select_n), .o_output_drive_n(o_output_drive_n),
		.o_addr(o_addr), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
		.i_data_in(i_data_in), .i_port_conflict_n(i_port_conflict_n));
	dpa_ram_mdl u_dpa_ram_mdl(.i_cs_n(o_chip_select_n), .i_we_n(o_write_not_read),
		.i_ub_n(o_upper_byte_sel_n), .i_lb_n(o_lower_byte_sel_n), .i_fs_n(o_flag_select_n),
		.i_od_n(o_output_drive_n), .i_cn(i_port_conflict_n), .i_a(o_addr), .i_d(i_data_in),
		.o_q(q));
	function logic [15:0] mrg(input logic [15:0] o, d, input logic [1:0] m);
		mrg = {m[1] ? d[15:8] : o[15:8], m[0] ? d[7:0] : o[7:0]};
	endfunction
	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string s, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task op(input logic w, f, input logic [1:0] m, input logic [3:0] ad, input logic [15:0] d);
		@(posedge i_clock) #1;
		{i_write, i_flag, i_bytes, i_addr, i_wdata, i_req} = {w, f, m, 8'h00, ad, d, 1'b1};
		@(posedge i_clock) #1 i_req = 0;
		chk("busy", 16'h0001, {15'h0000, o_busy});
		for (n = 0; n < 99 && o_done !== 1'b1; n++) @(posedge i_clock) #1;
		if (n == 99) begin
			miscompares++;
			final_report;
		end
		chk("idle", 16'h0000, {15'h0000, o_busy});
	endtask
	initial begin
		repeat (4) @(posedge i_clock);
		#1 i_rst = 0;
		// first sixteen passes fill the shadow, the rest are random byte writes
		for (int k = 0; k < 56; k++) begin
			r = $random(seed);
			a = k < 16 ? 4'(k) : r[7:4];
			b = k < 16 ? 2'h3 : r[9:8];
			i_oe_low = r[2];
			op(1, 0, b, a, r);
			sh[a] = mrg(sh[a], r, b);
			op(0, 0, 2'h3, a, r);
			chk("rdata", sh[a], o_rdata);
		end
		$display("array test done");
		for (int k = 0; k < 2; k++) begin
			op(1, 1, 2'h0, 4'h0, {15'h0000, k[0]});
			op(0, 1, 2'h0, 4'h0, r);
			chk("flag", {16{k[0]}}, o_rdata);
		end
		$display("flag test done");
		// far port won the location first; its flag releases after a bounded delay
		i_port_conflict_n = 0;
		fork
			op(1, 0, 2'h3, 4'h5, 16'hA5C3);
			begin
				repeat (6) @(posedge i_clock);
				#1 i_port_conflict_n = 1;
			end
		join
		op(0, 0, 2'h3, 4'h5, r);
		chk("held", 16'hA5C3, o_rdata);
		$display("conflict test done");
		final_report;
	end
endmodule // tb
